// ==== design/uart_ctl_map.vh ====
`ifndef UART_CTL_MAP_VH
`define UART_CTL_MAP_VH
// ---------------------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------------------
`define ADDR_DATA 12'h000
`define ADDR_IEN 12'h004
`define ADDR_ISRC 12'h008
`define ADDR_LFMT 12'h00C
`define ADDR_MOUT 12'h010
`define ADDR_LCOND 12'h014
`define ADDR_MIN 12'h018
`define ADDR_EVT 12'h01C
`define ADDR_STAT 12'h020
// ---------------------------------------------------------------------------
// Interrupt source codes
// ---------------------------------------------------------------------------
`define ICODE_LINE 4'h6
`define ICODE_TMO 4'hC
`define ICODE_RXD 4'h4
`define ICODE_TXR 4'h2
`define ICODE_MDM 4'h0
`define ICODE_NONE 4'h1
// ---------------------------------------------------------------------------
// Field positions, reset values and timeout lengths
// ---------------------------------------------------------------------------
`define FC_EN 0
`define FC_RXRST 1
`define FC_TXRST 2
`define FC_DMA 3
`define LF_PAR 3
`define LF_EVEN 4
`define LF_FORCE 5
`define LF_BRK 6
`define LF_DLAB 7
`define RST_BYTE 8'h00
`define TMO_CHARS 4
`define TMO_BITS 12
`endif

// ==== design/uart_irq_fifo_line_control.v ====
// Behaviour
// - Interrupt source read reports only the highest pending source; others wait.
// - Codes: line 0110, timeout 1100, rx data 0100, tx 0010, modem 0000, none 0001.
// - Source bit 0 is 0 while pending, 1 when none; resets to 1.
// - Line interrupt on line condition bits 1..4; cleared by reading that register.
// - Rx data interrupt at trigger level; clears when fill drops below it.
// - Rx timeout after four characters plus twelve bits; cleared by reading receive data.
// - Tx ready on tx FIFO empty; cleared by source read or transmit write.
// - Modem interrupt on change bits 0..3; cleared by reading modem input register.
// - Source bits 7:6 read 1 with FIFOs enabled, else 0; bits 5:4 zero.
// - FIFO enable bit must accompany other FIFO control bits or they are ignored.
// - FIFO reset bits clear rx or tx pointers once and self-clear.
// - FIFO control bit 3 selects DMA mode for the ready pins.
// - Trigger select 00/01/10/11 gives 1, 4, 8, 14 characters.
// - Line format bits 1:0 give 5, 6, 7 or 8 bit characters.
// - Stop bit select gives 1, 1.5 for 5-bit, or 2 stop bits.
// - Line format bit 3 enables parity generation and checking.
// - Bit 4 selects odd (0) or even (1) parity when not forced.
// - Bit 5 forces parity to 1 when bit 4 is 0, else 0.
// - Bit 6 holds serial output at 0 as break until cleared.
// - Bit 7 routes shared offsets to divisor latches.
// - Modem output bits 0,1 drive terminal ready and send request pins inverted.
// - Modem output bit 2 drives the spare output pin inverted; it supplies ring indicator in loopback.
// - Enable register masks receive, transmit, line and modem sources.
// - In loopback ring status equals modem output bit 2.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "uart_ctl_map.vh"
module uart_irq_fifo_line_control #(
  parameter FIFO_DEPTH = 16,
  parameter CLK_PER_BIT = 16
) (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Datapath status
  input wire [4:0] rx_level,
  input wire rx_push,
  input wire tx_empty,
  input wire [3:0] line_err,
  input wire [3:0] modem_in_n,
  input wire loopback,
  // Datapath controls
  output reg rx_fifo_clr,
  output reg tx_fifo_clr,
  output reg rx_pop,
  output reg tx_push,
  output reg [7:0] tx_data,
  output reg [7:0] divisor_low,
  output reg [7:0] divisor_high_latch,
  output reg [3:0] char_bits,
  output reg [1:0] stop_halfbits,
  output reg parity_en,
  output reg parity_bit_forced,
  output reg parity_forced_val,
  output reg parity_even,
  output reg serial_tx_break,
  output reg dma_mode,
  output reg fifo_en,
  // Pins
  output reg terminal_ready_n,
  output reg send_request_n,
  output reg spare_output_one_n,
  output reg irq
);
  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  reg [7:0] ien_r, lfmt_r, mout_r;
  reg [1:0] trig_sel_r;
  reg dma_r, fen_r;
  reg [3:0] lcond_r, mdelta_r;
  reg [3:0] min_prev_r;
  reg txr_r, tx_empty_prev_r, tmo_r;
  reg [15:0] tmo_cnt_r;
  reg [3:0] cur_code_r;
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire dlab = lfmt_r[`LF_DLAB];
  wire rd_data = rd && paddr == `ADDR_DATA && !dlab;
  wire rd_isrc = rd && paddr == `ADDR_ISRC;
  wire rd_lcond = rd && paddr == `ADDR_LCOND;
  wire rd_min = rd && paddr == `ADDR_MIN;
  wire wr_thr = wr && paddr == `ADDR_DATA && !dlab;
  // Trigger level lookup.
  reg [4:0] trig_lvl;
  always @* begin
    case (trig_sel_r)
      2'b00: trig_lvl = 5'd1;
      2'b01: trig_lvl = 5'd4;
      2'b10: trig_lvl = 5'd8;
      default: trig_lvl = 5'd14;
    endcase
  end
  wire rxd_pend = fen_r ? (rx_level >= trig_lvl) : (rx_level != 5'd0);
  // Timeout length in clocks: four characters of ten bits plus twelve bits.
  localparam integer TMO_CLKS_I = (`TMO_CHARS * 10 + `TMO_BITS) * CLK_PER_BIT;
  localparam [15:0] TMO_CLKS = TMO_CLKS_I[15:0];
  // Ring status follows the spare bit in loopback, else the inverted pin.
  wire [3:0] min_live = {~modem_in_n[3], loopback ? mout_r[2] : ~modem_in_n[2],
                         ~modem_in_n[1], ~modem_in_n[0]};
  // -------------------------------------------------------------------------
  // Priority encode
  // -------------------------------------------------------------------------
  reg [3:0] code_nxt;
  always @* begin
    if (ien_r[2] && lcond_r != 4'h0) code_nxt = `ICODE_LINE;
    else if (ien_r[0] && tmo_r) code_nxt = `ICODE_TMO;
    else if (ien_r[0] && rxd_pend) code_nxt = `ICODE_RXD;
    else if (ien_r[1] && txr_r) code_nxt = `ICODE_TXR;
    else if (ien_r[3] && mdelta_r != 4'h0) code_nxt = `ICODE_MDM;
    else code_nxt = `ICODE_NONE;
  end
  // -------------------------------------------------------------------------
  // Register file and sources
  // -------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_r <= `RST_BYTE;
      lfmt_r <= `RST_BYTE;
      mout_r <= `RST_BYTE;
      trig_sel_r <= 2'b00;
      dma_r <= 1'b0;
      fen_r <= 1'b0;
      lcond_r <= 4'h0;
      mdelta_r <= 4'h0;
      min_prev_r <= 4'h0;
      txr_r <= 1'b0;
      tx_empty_prev_r <= 1'b0;
      tmo_r <= 1'b0;
      tmo_cnt_r <= 16'h0000;
      cur_code_r <= `ICODE_NONE;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rx_fifo_clr <= 1'b0;
      tx_fifo_clr <= 1'b0;
      rx_pop <= 1'b0;
      tx_push <= 1'b0;
      tx_data <= 8'h00;
      divisor_low <= 8'h00;
      divisor_high_latch <= 8'h00;
      irq <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      rx_fifo_clr <= 1'b0;
      tx_fifo_clr <= 1'b0;
      rx_pop <= rd_data;
      tx_push <= wr_thr;
      min_prev_r <= min_live;
      tx_empty_prev_r <= tx_empty;
      // Sticky sources: a set in the same cycle as a clear wins.
      lcond_r <= (rd_lcond ? 4'h0 : lcond_r) | line_err;
      mdelta_r <= (rd_min ? 4'h0 : mdelta_r) | (min_live ^ min_prev_r);
      txr_r <= ((rd_isrc && cur_code_r == `ICODE_TXR) || wr_thr) ? 1'b0 : txr_r;
      if (tx_empty && !tx_empty_prev_r) txr_r <= 1'b1;
      if (wr && paddr == `ADDR_IEN && !dlab && pwdata[1] && tx_empty) txr_r <= 1'b1;
      // Timer restarts on a receive push, a receive data read or an empty FIFO and fires with data waiting while FIFOs are enabled.
      if (rx_push || rd_data || rx_level == 5'd0) tmo_cnt_r <= 16'h0000;
      else if (tmo_cnt_r != TMO_CLKS) tmo_cnt_r <= tmo_cnt_r + 16'h0001;
      // The timer firing wins over a data read in the same cycle.
      if (fen_r && tmo_cnt_r == TMO_CLKS - 16'h0001) tmo_r <= 1'b1;
      else if (rd_data) tmo_r <= 1'b0;
      // The code handed out in the setup cycle is kept so the access edge clears only that source.
      if (psel && !penable && !pwrite && paddr == `ADDR_ISRC)
        cur_code_r <= code_nxt;
      irq <= code_nxt != `ICODE_NONE;
      if (wr) begin
        case (paddr)
          `ADDR_DATA: begin
            if (dlab) divisor_low <= pwdata[7:0];
            else tx_data <= pwdata[7:0];
          end
          `ADDR_IEN: begin
            if (dlab) divisor_high_latch <= pwdata[7:0];
            else ien_r <= {4'h0, pwdata[3:0]};
          end
          `ADDR_ISRC: begin
            fen_r <= pwdata[`FC_EN];
            if (pwdata[`FC_EN]) begin
              trig_sel_r <= pwdata[7:6];
              dma_r <= pwdata[`FC_DMA];
              rx_fifo_clr <= pwdata[`FC_RXRST];
              tx_fifo_clr <= pwdata[`FC_TXRST];
            end
          end
          `ADDR_LFMT: lfmt_r <= pwdata[7:0];
          `ADDR_MOUT: mout_r <= {3'b000, pwdata[4:0]};
          default: begin
          end
        endcase
      end
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `ADDR_DATA: prdata <= {24'h0, dlab ? divisor_low : 8'h00};
          `ADDR_IEN: prdata <= {24'h0, dlab ? divisor_high_latch : ien_r};
          `ADDR_ISRC: prdata <= {24'h0, {2{fen_r}}, 2'b00, code_nxt};
          `ADDR_LFMT: prdata <= {24'h0, lfmt_r};
          `ADDR_MOUT: prdata <= {24'h0, mout_r};
          `ADDR_LCOND: prdata <= {27'h0, lcond_r, rx_level != 5'd0};
          `ADDR_MIN: prdata <= {24'h0, min_live, mdelta_r};
          `ADDR_EVT: prdata <= {27'h0, tmo_r, txr_r, rxd_pend, lcond_r != 4'h0, mdelta_r != 4'h0};
          `ADDR_STAT: prdata <= {24'h0, trig_sel_r, 2'b00, dma_r, 2'b00, fen_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
      // The error response must stand in the access cycle, for writes as well as reads.
      if (psel && !penable && (paddr > `ADDR_STAT || paddr[1:0] != 2'b00)) pslverr <= 1'b1;
    end
  end
  // -------------------------------------------------------------------------
  // Format and pin outputs
  // -------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      char_bits <= 4'd5;
      stop_halfbits <= 2'd2;
      parity_en <= 1'b0;
      parity_bit_forced <= 1'b0;
      parity_forced_val <= 1'b0;
      parity_even <= 1'b0;
      serial_tx_break <= 1'b0;
      dma_mode <= 1'b0;
      fifo_en <= 1'b0;
      terminal_ready_n <= 1'b1;
      send_request_n <= 1'b1;
      spare_output_one_n <= 1'b1;
    end else begin
      char_bits <= {2'b00, lfmt_r[1:0]} + 4'd5;
      stop_halfbits <= !lfmt_r[2] ? 2'd2 : (lfmt_r[1:0] == 2'b00 ? 2'd3 : 2'd0);
      parity_en <= lfmt_r[`LF_PAR];
      parity_even <= lfmt_r[`LF_EVEN];
      parity_bit_forced <= lfmt_r[`LF_PAR] & lfmt_r[`LF_FORCE];
      parity_forced_val <= ~lfmt_r[`LF_EVEN];
      serial_tx_break <= lfmt_r[`LF_BRK];
      dma_mode <= dma_r;
      fifo_en <= fen_r;
      terminal_ready_n <= ~mout_r[0];
      send_request_n <= ~mout_r[1];
      spare_output_one_n <= ~mout_r[2];
    end
  end
endmodule

// ==== test/uart_ctl_props.sv ====
`timescale 1ns/1ps
`include "uart_ctl_map.vh"
// ----
// Bus and control output checks
// ----
module uart_ctl_props (
  // Bus
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Controls
  input wire rx_fifo_clr,
  input wire [3:0] char_bits,
  input wire [1:0] stop_halfbits,
  input wire serial_tx_break,
  input wire terminal_ready_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire isrc_rd = acc && !pwrite && paddr == `ADDR_ISRC;
  wire fc_wr = acc && pwrite && paddr == `ADDR_ISRC;
  wire lf_wr = acc && pwrite && paddr == `ADDR_LFMT;
  wire mo_wr = acc && pwrite && paddr == `ADDR_MOUT;
  a_pready_access: assert property (acc |-> pready)
    else $error("pready low in access cycle");
  a_unmapped_err: assert property (acc && paddr > `ADDR_STAT |-> pslverr)
    else $error("unmapped access without error");
  a_isrc_code: assert property (isrc_rd |-> prdata[3:0] inside {4'h6, 4'hC, 4'h4, 4'h2, 4'h0, 4'h1})
    else $error("illegal source code");
  a_isrc_fifo_bits: assert property (isrc_rd |-> prdata[5:4] == 2'b00 && prdata[7] == prdata[6])
    else $error("bad source upper bits");
  a_char_len: assert property (char_bits >= 4'd5 && char_bits <= 4'd8)
    else $error("char length out of range");
  a_half_stop: assert property (stop_halfbits == 2'd3 |-> char_bits == 4'd5)
    else $error("half stop on long char");
  a_break_cause: assert property ($rose(serial_tx_break) |-> $past(lf_wr) || $past(lf_wr, 2))
    else $error("break without format write");
  a_rxclr_once: assert property (rx_fifo_clr |-> ($past(fc_wr) || $past(fc_wr, 2)) ##1 !rx_fifo_clr)
    else $error("rx clear not a single pulse");
  a_dtr_cause: assert property ($changed(terminal_ready_n) |-> $past(mo_wr) || $past(mo_wr, 2))
    else $error("ready pin moved without write");
  c_line: cover property (isrc_rd && prdata[3:0] == `ICODE_LINE);
  c_break: cover property (serial_tx_break);
  c_clr: cover property (rx_fifo_clr);
endmodule
bind uart_irq_fifo_line_control uart_ctl_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_fifo_clr(rx_fifo_clr), .char_bits(char_bits), .stop_halfbits(stop_halfbits),
  .serial_tx_break(serial_tx_break), .terminal_ready_n(terminal_ready_n));

// ==== test/uart_far_end.sv ====
`timescale 1ns/1ps
// ----
// Far side datapath and modem pins
// ----
module uart_far_end (
  // Clock
  input wire pclk,
  // Status
  output logic [4:0] rx_level = 5'h00,
  output logic rx_push = 1'b0,
  output logic tx_empty = 1'b0,
  output logic [3:0] line_err = 4'h0,
  output logic [3:0] modem_in_n = 4'hF,
  output logic loopback = 1'b0
);
  // Strobes last one clock, like the real datapath; levels stay until the next call.
  task automatic drive(input logic [4:0] lvl, input logic push, input logic [3:0] err, input logic [3:0] flip,
                       input logic txe, input logic lb);
    @(posedge pclk);
    rx_level <= lvl;
    rx_push <= push;
    line_err <= err;
    modem_in_n <= modem_in_n ^ flip;
    tx_empty <= txe;
    loopback <= lb;
    @(posedge pclk);
    rx_push <= 1'b0;
    line_err <= 4'h0;
  endtask
endmodule

// ==== test/uart_irq_fifo_line_control_tb.sv ====
`timescale 1ns/1ps
`include "uart_ctl_map.vh"
module uart_irq_fifo_line_control_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic err_seen;
  logic clr_seen = 1'b0;
  logic [2:0] pulse_seen = 3'b000;
  integer fails = 0;
  integer check_count = 0;
  wire pready, pslverr, rx_fifo_clr, tx_fifo_clr, rx_pop, tx_push, parity_en, parity_bit_forced, rx_push, tx_empty;
  wire parity_forced_val, parity_even, serial_tx_break, dma_mode, fifo_en, loopback, irq;
  wire terminal_ready_n, send_request_n, spare_output_one_n;
  wire [31:0] prdata;
  wire [7:0] tx_data, divisor_low, divisor_high_latch;
  wire [4:0] rx_level;
  wire [3:0] char_bits, line_err, modem_in_n;
  wire [1:0] stop_halfbits;
  // ----
  // Design, far side and helpers
  // ----
  // A short bit time keeps the receive timeout wait small.
  uart_irq_fifo_line_control #(.CLK_PER_BIT(4)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rx_level, .rx_push, .tx_empty, .line_err, .modem_in_n, .loopback, .rx_fifo_clr,
    .tx_fifo_clr, .rx_pop, .tx_push, .tx_data, .divisor_low, .divisor_high_latch, .char_bits, .stop_halfbits,
    .parity_en, .parity_bit_forced, .parity_forced_val, .parity_even, .serial_tx_break, .dma_mode, .fifo_en,
    .terminal_ready_n, .send_request_n, .spare_output_one_n, .irq);
  uart_far_end far (.pclk, .rx_level, .rx_push, .tx_empty, .line_err, .modem_in_n, .loopback);
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) if (rx_fifo_clr === 1'b1) clr_seen <= 1'b1;
  always @(posedge pclk) pulse_seen <= pulse_seen | {tx_fifo_clr === 1'b1, rx_pop === 1'b1, tx_push === 1'b1};
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic isrc(input logic [3:0] code);
    apb(0, `ADDR_ISRC, 0);
    chk("isrc", code, rdata[3:0]);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_format;
    logic [7:0] pv [5] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'h40};
    isrc(`ICODE_NONE);
    chk("pins", 32'h5B, {24'h0, char_bits, stop_halfbits, terminal_ready_n, send_request_n});
    for (int i = 0; i < 4; i++) begin
      apb(1, `ADDR_LFMT, 32'h4 | i);
      repeat (2) @(posedge pclk);
      chk("char_bits", 5 + i, char_bits);
      chk("stop", (i == 0) ? 3 : 0, stop_halfbits);
    end
    foreach (pv[k]) begin
      apb(1, `ADDR_LFMT, pv[k]);
      repeat (2) @(posedge pclk);
      chk("par_en", pv[k][3], parity_en);
      chk("forced", pv[k][5], parity_bit_forced);
      if (pv[k][5]) chk("force_val", !pv[k][4], parity_forced_val);
      else chk("even", pv[k][4], parity_even);
      chk("break", pv[k][6], serial_tx_break);
    end
    apb(1, `ADDR_LFMT, 32'h83);
    apb(1, `ADDR_IEN, 32'h5A);
    apb(1, `ADDR_DATA, 32'h3C);
    apb(1, `ADDR_LFMT, 32'h03);
    apb(1, `ADDR_DATA, 32'h77);
    apb(0, `ADDR_IEN, 0);
    chk("ien", 0, rdata);
    chk("divisor", 32'h5A3C, {divisor_high_latch, divisor_low});
    chk("tx_data", 32'h77, tx_data);
    chk("tx_push", 1, pulse_seen[0]);
    chk("break_off", 0, serial_tx_break);
    apb(0, 12'h024, 0);
    chk("slverr", 1, err_seen);
    apb(1, 12'h024, 32'h0000_00FF);
    chk("slverr_wr", 1, err_seen);
    $display("test format done");
  endtask
  task automatic t_fifo;
    int trig [4] = '{1, 4, 8, 14};
    apb(1, `ADDR_ISRC, 32'hC1);
    apb(0, `ADDR_ISRC, 0);
    chk("fifo_bits", 2'b11, rdata[7:6]);
    apb(1, `ADDR_ISRC, 32'h08);
    apb(0, `ADDR_ISRC, 0);
    chk("fifo_off", 2'b00, rdata[7:6]);
    chk("dma", 0, dma_mode);
    apb(1, `ADDR_ISRC, 32'h0F);
    repeat (2) @(posedge pclk);
    chk("dma_on", 1, dma_mode);
    chk("rx_clr", 1, clr_seen);
    chk("tx_clr", 1, pulse_seen[2]);
    chk("fifo_en", 1, fifo_en);
    apb(1, `ADDR_IEN, 32'h01);
    foreach (trig[k]) begin
      apb(1, `ADDR_ISRC, {k[1:0], 6'h01});
      far.drive(5'(trig[k]), 0, 0, 0, 0, 0);
      isrc(`ICODE_RXD);
      far.drive(5'(trig[k] - 1), 0, 0, 0, 0, 0);
      isrc(`ICODE_NONE);
    end
    apb(1, `ADDR_ISRC, 32'h41);
    far.drive(5'd1, 1, 0, 0, 0, 0);
    repeat (216) @(posedge pclk);
    isrc(`ICODE_TMO);
    apb(0, `ADDR_DATA, 0);
    isrc(`ICODE_NONE);
    chk("rx_pop", 1, pulse_seen[1]);
    $display("test fifo done");
  endtask
  task automatic t_irq;
    apb(1, `ADDR_IEN, 32'h00);
    far.drive(0, 0, 4'h2, 4'h1, 1, 0);
    isrc(`ICODE_NONE);
    chk("irq_off", 0, irq);
    apb(1, `ADDR_IEN, 32'h0E);
    isrc(`ICODE_LINE);
    chk("irq_on", 1, irq);
    apb(0, `ADDR_LCOND, 0);
    isrc(`ICODE_TXR);
    isrc(`ICODE_MDM);
    far.drive(0, 0, 4'h4, 0, 1, 0);
    isrc(`ICODE_LINE);
    apb(0, `ADDR_LCOND, 0);
    apb(0, `ADDR_MIN, 0);
    isrc(`ICODE_NONE);
    repeat (2) @(posedge pclk);
    chk("irq_clear", 0, irq);
    apb(1, `ADDR_MOUT, 32'h03);
    repeat (2) @(posedge pclk);
    chk("mpins", 3'b001, {terminal_ready_n, send_request_n, spare_output_one_n});
    apb(1, `ADDR_MOUT, 32'h04);
    far.drive(0, 0, 0, 0, 1, 1);
    apb(0, `ADDR_MIN, 0);
    chk("ring", 1, rdata[6]);
    chk("mpins2", 3'b110, {terminal_ready_n, send_request_n, spare_output_one_n});
    $display("test irq done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_format;
    t_fifo;
    t_irq;
    tally_and_finish;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    tally_and_finish;
  end
endmodule
